// [core/pmrc_defs.vh]
`ifndef PMRC_DEFS_VH
`define PMRC_DEFS_VH
// register byte addresses
`define PMRC_ADDR_POWER_CONTROL_REGISTER     12'h000
`define PMRC_ADDR_BANK     12'h004
`define PMRC_ADDR_WD_PER   12'h008
`define PMRC_ADDR_WD_KEY   12'h00C
`define PMRC_ADDR_STATUS   12'h010
// field positions
`define PMRC_POWER_CONTROL_REGISTER_HALT     0
`define PMRC_POWER_CONTROL_REGISTER_DEEP     1
`define PMRC_BANK_LOWACT   0
// reset values and watchdog unlock key
`define PMRC_RST_PER       8'h00
`define PMRC_RST_KEY       8'h00
`define PMRC_UNLOCK_VALUE  8'h55
// timing
`define PMRC_CLK_HZ        25000000
`define PMRC_POR_CYCLES    8'h10
`define PMRC_EXT_RST_NS    2000
// 2 us hold counted in 40 ns clocks
`define PMRC_EXT_RST_CYC   8'h32
`endif

// [core/pmrc_sync.v]
`timescale 1ns/100ps
`default_nettype none
module pmrc_sync (
  input  wire mclk_i,
  input  wire rst_b_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg q_reg;
  // first stage feeds only the second stage
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end
  assign q_o = q_reg;
endmodule
`default_nettype wire

// [core/pmrc_clk_gate.v]
`timescale 1ns/100ps
`default_nettype none
module pmrc_clk_gate (
  input  wire mclk_i,
  input  wire en_i,
  output wire gclk_o
);
  reg en_neg_reg;
  // enable taken on the falling edge, so it only changes while the clock is low
  always @(negedge mclk_i) begin
    en_neg_reg <= en_i;
  end
  assign gclk_o = mclk_i & en_neg_reg;
endmodule
`default_nettype wire

// [core/pmrc_top.v]
// Overview of operation
// - power-on reset made internally, no network
// - this block issues master reset to cpu
// - effective reset is external OR power-on OR watchdog expiry
// - external reset active high, reads low
// - saving only by gating section clocks
// - standby gates acquisition and display clocks
// - low activity select bit enters standby
// - oscillator keeps running, derived clocks gated
// - wake from idle keeps standby sections off
// - idle gates cpu, acquisition and display
// - cpu halt bit enters idle
// - idle freezes cpu, state retained
// - enabled interrupt clears halt, ends idle
// - comparator interrupt wakes from idle
// - hardware reset ends idle, short hold
// - reset presets registers, pc to zero
// - deep sleep bit enters power-down
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_defs.vh"
module pmrc_top #(
  parameter [7:0] POR_CYCLES = `PMRC_POR_CYCLES
) (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire        ext_rst_i,
  input  wire        irq_pending_i,
  input  wire        cmp_irq_i,
  input  wire        wd_expire_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  output wire        master_rst_o,
  output wire        cpu_clk_o,
  output wire        acq_clk_o,
  output wire        disp_clk_o,
  output wire        periph_clk_o,
  output wire        osc_run_o,
  output reg  [7:0]  wd_period_o,
  output reg         wd_enable_o,
  output wire        standby_o,
  output wire        idle_o,
  output wire        deep_sleep_o
);
  // ****************************************************************
  // reset generation
  // ****************************************************************
  reg  [7:0] por_cnt_reg;
  reg        por_active_reg;
  wire       ext_rst_sync;
  reg  [7:0] ext_cnt_reg;
  reg        ext_rst_reg;
  localparam [7:0] EXT_CYC = `PMRC_EXT_RST_CYC;
  localparam [7:0] POR_MAX = POR_CYCLES;

  // pin has pull-down in the pad; low means not asserted
  pmrc_sync u_ext_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .d_i     (ext_rst_i),
    .q_o     (ext_rst_sync)
  );

  // power-on counter is only cleared by the supply-level reset
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      por_cnt_reg    <= 8'h00;
      por_active_reg <= 1'b1;
    end else if (por_cnt_reg != POR_MAX) begin
      por_cnt_reg    <= por_cnt_reg + 8'h01;
      por_active_reg <= 1'b1;
    end else begin
      por_active_reg <= 1'b0;
    end
  end

  // external pulse must be held for the full count before it is honoured
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ext_cnt_reg <= 8'h00;
      ext_rst_reg <= 1'b0;
    end else if (!ext_rst_sync) begin
      ext_cnt_reg <= 8'h00;
      ext_rst_reg <= 1'b0;
    end else if (ext_cnt_reg != EXT_CYC) begin
      ext_cnt_reg <= ext_cnt_reg + 8'h01;
    end else begin
      ext_rst_reg <= 1'b1;
    end
  end

  wire sys_rst = por_active_reg | ext_rst_reg | wd_expire_i;
  assign master_rst_o = sys_rst;

  // ****************************************************************
  // mode control registers
  // ****************************************************************
  reg       halt_reg;
  reg       deep_reg;
  reg       lowact_reg;
  reg [7:0] key_reg;
  wire      wr_en = psel_i & penable_i & pwrite_i;
  wire      rd_hit;
  wire      wake = irq_pending_i | cmp_irq_i;

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  always @(posedge mclk_i) begin
    if (!rst_b_i || sys_rst) begin
      halt_reg    <= 1'b0;
      deep_reg    <= 1'b0;
      lowact_reg  <= 1'b0;
      key_reg     <= `PMRC_RST_KEY;
      wd_period_o <= `PMRC_RST_PER;
      wd_enable_o <= 1'b1;
    end else begin
      // wake wins over a write of the same cycle
      if (wake) begin
        halt_reg <= 1'b0;
        deep_reg <= 1'b0;
      end else if (wr_en && is_addr(paddr_i, `PMRC_ADDR_POWER_CONTROL_REGISTER)) begin
        halt_reg <= pwdata_i[`PMRC_POWER_CONTROL_REGISTER_HALT];
        deep_reg <= pwdata_i[`PMRC_POWER_CONTROL_REGISTER_DEEP];
      end
      // lowact survives the wake so acquisition stays off
      if (wr_en && is_addr(paddr_i, `PMRC_ADDR_BANK)) begin
        lowact_reg <= pwdata_i[`PMRC_BANK_LOWACT];
      end
      if (wr_en && is_addr(paddr_i, `PMRC_ADDR_WD_PER)) begin
        wd_period_o <= pwdata_i[7:0];
      end
      if (wr_en && is_addr(paddr_i, `PMRC_ADDR_WD_KEY)) begin
        key_reg <= pwdata_i[7:0];
        if (pwdata_i[7:0] == `PMRC_UNLOCK_VALUE) begin
          wd_enable_o <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // clock gating
  // ****************************************************************
  wire cpu_en    = ~halt_reg & ~deep_reg;
  wire sect_en   = ~lowact_reg & ~halt_reg & ~deep_reg;
  wire periph_en = ~deep_reg;

  // only the derived clocks are gated; supplies stay on
  assign osc_run_o = 1'b1;

  pmrc_clk_gate u_cpu_gate (
    .mclk_i (mclk_i),
    .en_i   (cpu_en),
    .gclk_o (cpu_clk_o)
  );
  pmrc_clk_gate u_acq_gate (
    .mclk_i (mclk_i),
    .en_i   (sect_en),
    .gclk_o (acq_clk_o)
  );
  pmrc_clk_gate u_disp_gate (
    .mclk_i (mclk_i),
    .en_i   (sect_en),
    .gclk_o (disp_clk_o)
  );
  pmrc_clk_gate u_per_gate (
    .mclk_i (mclk_i),
    .en_i   (periph_en),
    .gclk_o (periph_clk_o)
  );

  assign standby_o    = lowact_reg;
  assign idle_o       = halt_reg;
  assign deep_sleep_o = deep_reg;

  // ****************************************************************
  // apb read path
  // ****************************************************************
  assign pready_o  = 1'b1;
  assign rd_hit    = is_addr(paddr_i, `PMRC_ADDR_POWER_CONTROL_REGISTER) | is_addr(paddr_i, `PMRC_ADDR_BANK) |
                     is_addr(paddr_i, `PMRC_ADDR_WD_PER) | is_addr(paddr_i, `PMRC_ADDR_WD_KEY) |
                     is_addr(paddr_i, `PMRC_ADDR_STATUS);
  assign pslverr_o = psel_i & penable_i & ~rd_hit;

  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h0000_0000;
    if (is_addr(paddr_i, `PMRC_ADDR_POWER_CONTROL_REGISTER)) begin
      rd_word[`PMRC_POWER_CONTROL_REGISTER_HALT] = halt_reg;
      rd_word[`PMRC_POWER_CONTROL_REGISTER_DEEP] = deep_reg;
    end else if (is_addr(paddr_i, `PMRC_ADDR_BANK)) begin
      rd_word[`PMRC_BANK_LOWACT] = lowact_reg;
    end else if (is_addr(paddr_i, `PMRC_ADDR_WD_PER)) begin
      rd_word[7:0] = wd_period_o;
    end else if (is_addr(paddr_i, `PMRC_ADDR_WD_KEY)) begin
      rd_word[7:0] = key_reg;
    end else if (is_addr(paddr_i, `PMRC_ADDR_STATUS)) begin
      rd_word[3:0] = {wd_enable_o, ext_rst_reg, por_active_reg, sect_en};
    end
  end

  // word captured in the setup phase, so it stands through a zero-wait access
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rd_word;
    end
  end
endmodule
`default_nettype wire

// [tb/pmrc_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module pmrc_top_sva (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        irq_pending_i,
  input wire logic        cmp_irq_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        master_rst_o,
  input wire logic [7:0]  wd_period_o,
  input wire logic        wd_enable_o,
  input wire logic        standby_o,
  input wire logic        idle_o,
  input wire logic        deep_sleep_o
);
  // ****************
  // mode checks
  // ****************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic wr   = psel_i & penable_i & pwrite_i & !master_rst_o;
  // a wake request wins over a same-cycle halt write
  wire logic wake = irq_pending_i | cmp_irq_i;
  AST_HALT:
    assert property (wr && paddr_i == 12'h000 && pwdata_i[0] && !wake |=> idle_o)
      else $error("halt write ignored");
  AST_DEEP:
    assert property (wr && paddr_i == 12'h000 && pwdata_i[1] && !wake |=> deep_sleep_o)
      else $error("deep sleep write ignored");
  AST_WAKE:
    assert property (idle_o && irq_pending_i |=> !idle_o) else $error("irq kept idle");
  AST_CMP:
    assert property (idle_o && cmp_irq_i |=> !idle_o) else $error("comparator kept idle");
  AST_STBY:
    assert property (wr && paddr_i == 12'h004 |=> standby_o == $past(pwdata_i[0]))
      else $error("standby bit wrong");
  AST_KEY:
    assert property (wr && paddr_i == 12'h00C && pwdata_i[7:0] == 8'h55 |=> !wd_enable_o)
      else $error("key did not stop watchdog");
  AST_PER:
    assert property (wr && paddr_i == 12'h008 |=> wd_period_o == $past(pwdata_i[7:0]))
      else $error("period not stored");
  AST_RST:
    assert property (master_rst_o |=> !idle_o && !standby_o && wd_period_o == 8'h00)
      else $error("reset left state");
endmodule
bind pmrc_top pmrc_top_sva u_sva (.mclk_i, .rst_b_i, .irq_pending_i, .cmp_irq_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .master_rst_o, .wd_period_o, .wd_enable_o,
  .standby_o, .idle_o, .deep_sleep_o);
`default_nettype wire

// [tb/pmrc_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pmrc_cpu_model (
  input  wire logic       mclk_i,
  input  wire logic       idle_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [7:0] dly_i,
  output var  logic       irq_pending_o = 1'b0,
  output var  logic       cmp_irq_o = 1'b0
);
  // ****************
  // wake source
  // ****************
  logic [7:0] cnt_reg = 8'h00;
  // one-cycle pulse: a level that lingers would hide a missing wake
  always @(posedge mclk_i) begin
    cnt_reg <= idle_i ? cnt_reg + 8'h01 : 8'h00;
    irq_pending_o <= idle_i && cnt_reg == dly_i && mode_i == 2'h1;
    cmp_irq_o <= idle_i && cnt_reg == dly_i && mode_i == 2'h2;
  end
endmodule
`default_nettype wire

// [tb/power_mode_reset_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module power_mode_reset_control_bench;
  // ****************
  // bench
  // ****************
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, ext_rst_i = 1'b0, wd_expire_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, perr_s;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        irq_pending_i, cmp_irq_i, pready_o, pslverr_o, master_rst_o, osc_run_o;
  logic        cpu_clk_o, acq_clk_o, disp_clk_o, periph_clk_o;
  logic        wd_enable_o, standby_o, idle_o, deep_sleep_o;
  logic [7:0]  wd_period_o;
  logic [1:0]  wake_mode = 2'h0;
  int          error_cnt = 0, comparisons = 0, nc = 0, na = 0, nd = 0, np = 0;
  initial forever #20 mclk_i = ~mclk_i;
  always @(posedge cpu_clk_o) nc++;
  always @(posedge acq_clk_o) na++;
  always @(posedge disp_clk_o) nd++;
  always @(posedge periph_clk_o) np++;
  pmrc_top #(.POR_CYCLES(8'h04)) dut (.*);
  pmrc_cpu_model model (.mclk_i, .idle_i(idle_o), .mode_i(wake_mode), .dly_i(8'h20),
    .irq_pending_o(irq_pending_i), .cmp_irq_o(cmp_irq_i));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    perr_s = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  // edges seen per section clock: {cpu, acquisition, display, peripheral}
  task gates(input logic [3:0] exp);
    int c, a, d, p;
    c = nc;
    a = na;
    d = nd;
    p = np;
    repeat (6) @(posedge mclk_i);
    chk({nc > c, na > a, nd > d, np > p}, exp);
  endtask
  task t_reset;
    chk(master_rst_o, 1'b0);
    chk(osc_run_o, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(perr_s, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h9);
    gates(4'hF);
    $display("reset test done");
  endtask
  task t_standby;
    apb(1'b1, 12'h004, 32'h1);
    chk(standby_o, 1'b1);
    gates(4'h9);
    $display("standby test done");
  endtask
  task t_idle(input logic [1:0] m);
    wake_mode <= m;
    apb(1'b1, 12'h00C, 32'h55);
    chk(wd_enable_o, 1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h55);
    apb(1'b1, 12'h008, 32'hA5);
    apb(1'b1, 12'h000, 32'h1);
    chk(idle_o, 1'b1);
    gates(4'h1);
    repeat (40) @(posedge mclk_i);
    chk(idle_o, 1'b0);
    gates(4'h9);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'hA5);
    $display("idle test done");
  endtask
  task t_ext;
    wake_mode <= 2'h0;
    apb(1'b1, 12'h000, 32'h3);
    chk(deep_sleep_o, 1'b1);
    gates(4'h0);
    @(posedge mclk_i);
    ext_rst_i <= 1'b1;
    repeat (60) @(posedge mclk_i);
    chk(master_rst_o, 1'b1);
    ext_rst_i <= 1'b0;
    repeat (30) @(posedge mclk_i);
    chk({master_rst_o, idle_o, standby_o, deep_sleep_o}, 4'h0);
    gates(4'hF);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    chk(wd_enable_o, 1'b1);
    apb(1'b1, 12'h00C, 32'h55);
    @(posedge mclk_i);
    wd_expire_i <= 1'b1;
    @(negedge mclk_i);
    chk(master_rst_o, 1'b1);
    @(posedge mclk_i);
    wd_expire_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk({master_rst_o, wd_enable_o}, 2'h1);
    $display("external reset test done");
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    t_reset;
    t_standby;
    t_idle(2'h1);
    t_idle(2'h2);
    t_ext;
    stop_test;
  end
endmodule
`default_nettype wire
